// ### cld_decoder.sv
// Overview of operation
// - Host transfers latch into instruction or payload register, then execute.
// - Each RAM access steps the address counter by one, up or down.
// - Status read shows busy as one on bit 7 while executing.
// - Clear fills text RAM with spaces and zeroes the address counter.
// - Clear also forces the step direction to increment.
// - Return home zeroes address counter and display shift, RAM unchanged.
// - Clear and return home stay busy about 1.53 ms.
// - Entry mode loads step direction from bit 1, auto scroll from bit 0.
// - Glyph RAM accesses step the address counter like text RAM.
// - Text writes with auto scroll shift display left if incrementing.
// - No display shift on reads, glyph accesses, or auto scroll clear.
// - On/off command loads screen, cursor and flash from bits 2..0.
// - Shift command takes target bit 3, direction bit 2; busy 39 us.
// - Function set loads bus width, line count and glyph height.
// - Bits 7:6 equal 01 load glyph address and select glyph RAM.
// - Bit 7 set loads text address and selects text RAM.
// - Status read returns busy and address counter, accepted while busy.
// - Data write stores byte at address counter, busy about 43 us.
// - Data read returns byte at address counter, busy about 43 us.
// - Screen off blanks display; cursor controls gate only the cursor.
// - Cursor shift steps address; display shift moves lines, counter kept.
// - Narrow bus exchanges each byte as two nibbles on upper lines.
// - Two-line text RAM spans 00H-27H and 40H-67H.
`timescale 1ns/1ps
`default_nettype none
module cld_decoder
    import cld_pkg::*;
#(
    parameter int CLR_CYC  = EXEC_CLR_CYC,
    parameter int DATA_CYC = EXEC_DATA_CYC
)
(
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              reset_in,
    // Host bus
    input  wire logic              reg_sel_in,
    input  wire logic              read_in,
    input  wire logic              strobe_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_out,
    // Display controls
    output logic                   screen_on_out,
    output logic                   cursor_show_out,
    output logic                   blink_show_out,
    output logic                   two_line_out,
    output logic                   tall_font_out,
    output logic                   bus_width_out,
    output logic      [TEXT_AW-1:0] display_offset_out,
    output logic      [TEXT_AW-1:0] cursor_addr_out
);

    function automatic cld_cmd_e decode_cmd(input logic [DATA_W-1:0] b);
        cld_cmd_e c;
        c = CMD_NOP;
        if (b[CMD_DDADDR])     c = CMD_DDA;
        else if (b[CMD_CGADDR]) c = CMD_CGA;
        else if (b[CMD_FUNC])  c = CMD_FUN;
        else if (b[CMD_SHIFT]) c = CMD_SHF;
        else if (b[CMD_ONOFF]) c = CMD_ONF;
        else if (b[CMD_ENTRY]) c = CMD_ENT;
        else if (b[CMD_HOME])  c = CMD_HOM;
        else if (b[CMD_CLEAR]) c = CMD_CLR;
        return c;
    endfunction : decode_cmd

    // Address step with line wrap for text RAM
    function automatic logic [TEXT_AW-1:0] step_addr(
        input logic [TEXT_AW-1:0] a,
        input logic               up,
        input logic               text,
        input logic               two
    );
        logic [TEXT_AW-1:0] r;
        r = a;
        if (!text) begin
            r = up ? {1'b0, a[GLYPH_AW-1:0] + 1'b1}
                   : {1'b0, a[GLYPH_AW-1:0] - 1'b1};
        end else if (two) begin
            if (up) begin
                r = (a == LINE1_END) ? LINE2_START
                  : (a == LINE2_END) ? ADDR_ZERO : a + 1'b1;
            end else begin
                r = (a == ADDR_ZERO) ? LINE2_END
                  : (a == LINE2_START) ? LINE1_END : a - 1'b1;
            end
        end else begin
            if (up) begin
                r = (a == ONE_LINE_END) ? ADDR_ZERO : a + 1'b1;
            end else begin
                r = (a == ADDR_ZERO) ? ONE_LINE_END : a - 1'b1;
            end
        end
        return r;
    endfunction : step_addr

    // State
    cld_ctl_s           ctl;
    cld_op_e            op_q;
    logic [DATA_W-1:0]  instr_reg;
    logic [DATA_W-1:0]  payload_reg;
    logic [DATA_W-1:0]  rd_byte;
    logic [NIB_W-1:0]   hi_nib;
    logic [TEXT_AW-1:0] addr_counter;
    logic [TEXT_AW-1:0] disp_offset;
    logic [TEXT_AW-1:0] fill_idx;
    logic               fill_active;
    logic               sel_text;
    logic               strobe_q;
    logic               nib_phase;

    // Next values
    cld_ctl_s           next_ctl;
    cld_op_e            next_op;
    logic [TEXT_AW-1:0] next_addr;
    logic [TEXT_AW-1:0] next_offset;
    logic               next_sel;

    // Host side decode
    logic               strobe_rise;
    logic               strobe_fall;
    logic               byte_done;
    logic               first_rise;
    logic               accept;
    logic [DATA_W-1:0]  wr_byte;
    logic [DATA_W-1:0]  sel_byte;
    logic [DATA_W-1:0]  ram_rd;
    logic [DATA_W-1:0]  text_rd;
    logic [DATA_W-1:0]  glyph_rd;
    logic               busy_flag;
    logic               tmr_busy;

    // Execution decode
    cld_cmd_e           cmd;
    logic               exec_instr;
    logic               exec_write;
    logic               exec_read;
    logic               exec_long;
    logic               tmr_load;
    logic [TMR_W-1:0]   exec_cyc;
    logic [TEXT_AW-1:0] step_next;
    logic               text_we;
    logic [TEXT_AW-1:0] text_wa;
    logic [DATA_W-1:0]  text_wd;
    logic               glyph_we;

    assign strobe_rise = strobe_in & ~strobe_q;
    assign strobe_fall = ~strobe_in & strobe_q;
    assign byte_done   = strobe_fall & (ctl.bus_width | nib_phase);
    assign first_rise  = strobe_rise & (ctl.bus_width | ~nib_phase);
    assign busy_flag   = (op_q != OP_NONE) | tmr_busy | fill_active;
    assign accept      = byte_done & ~busy_flag;
    assign wr_byte     = ctl.bus_width ? data_in
                       : {hi_nib, data_in[DATA_W-1 -: NIB_W]};
    assign ram_rd      = sel_text ? text_rd : glyph_rd;
    assign sel_byte    = reg_sel_in ? ram_rd
                       : {busy_flag, addr_counter};
    assign next_op     = !accept ? OP_NONE
                       : (!read_in && !reg_sel_in) ? OP_INSTR
                       : (!read_in) ? OP_WRITE
                       : reg_sel_in ? OP_READ : OP_NONE;

    assign cmd        = decode_cmd(instr_reg);
    assign exec_instr = (op_q == OP_INSTR);
    assign exec_write = (op_q == OP_WRITE);
    assign exec_read  = (op_q == OP_READ);
    assign exec_long  = exec_instr & (cmd == CMD_CLR || cmd == CMD_HOM);
    assign tmr_load   = (op_q != OP_NONE) & ~(exec_instr & cmd == CMD_NOP);
    assign exec_cyc   = exec_long ? TMR_W'(CLR_CYC)
                      : (exec_write | exec_read) ? TMR_W'(DATA_CYC)
                      : TMR_W'(EXEC_SHORT_CYC);
    assign step_next  = step_addr(addr_counter, ctl.step_inc,
                                  sel_text, ctl.two_line);

    assign text_we  = fill_active | (exec_write & sel_text);
    assign text_wa  = fill_active ? fill_idx : addr_counter;
    assign text_wd  = fill_active ? SPACE_CODE : payload_reg;
    assign glyph_we = exec_write & ~sel_text;

    always_comb begin
        next_ctl    = ctl;
        next_addr   = addr_counter;
        next_offset = disp_offset;
        next_sel    = sel_text;
        if (exec_write || exec_read) begin
            next_addr = step_next;
            if (exec_write && sel_text && ctl.auto_scroll) begin
                next_offset = ctl.step_inc ? disp_offset + 1'b1
                                           : disp_offset - 1'b1;
            end
        end else if (exec_instr) begin
            unique case (cmd)
                CMD_NOP: begin
                end
                CMD_CLR: begin
                    next_addr        = ADDR_ZERO;
                    next_offset      = ADDR_ZERO;
                    next_sel         = 1'b1;
                    next_ctl.step_inc = 1'b1;
                end
                CMD_HOM: begin
                    next_addr   = ADDR_ZERO;
                    next_offset = ADDR_ZERO;
                    next_sel    = 1'b1;
                end
                CMD_ENT: begin
                    next_ctl.step_inc    = instr_reg[BIT_STEP_INC];
                    next_ctl.auto_scroll = instr_reg[BIT_SCROLL];
                end
                CMD_ONF: begin
                    next_ctl.screen_on = instr_reg[BIT_SCREEN];
                    next_ctl.cursor_on = instr_reg[BIT_CURSOR];
                    next_ctl.blink_on  = instr_reg[BIT_BLINK];
                end
                CMD_SHF: begin
                    if (instr_reg[BIT_TARGET]) begin
                        next_offset = instr_reg[BIT_RIGHT]
                                    ? disp_offset - 1'b1
                                    : disp_offset + 1'b1;
                    end else begin
                        next_addr = step_addr(addr_counter,
                                              instr_reg[BIT_RIGHT],
                                              sel_text, ctl.two_line);
                    end
                end
                CMD_FUN: begin
                    next_ctl.bus_width = instr_reg[BIT_WIDTH];
                    next_ctl.two_line  = instr_reg[BIT_LINES];
                    next_ctl.tall_font = instr_reg[BIT_FONT];
                end
                CMD_CGA: begin
                    next_addr = {1'b0, instr_reg[GLYPH_AW-1:0]};
                    next_sel  = 1'b0;
                end
                CMD_DDA: begin
                    next_addr = instr_reg[TEXT_AW-1:0];
                    next_sel  = 1'b1;
                end
            endcase
        end
    end

    // Host bus capture and nibble pairing
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            strobe_q  <= 1'b0;
            nib_phase <= 1'b0;
            hi_nib    <= NIB_ZERO;
        end else begin
            strobe_q <= strobe_in;
            if (ctl.bus_width) begin
                nib_phase <= 1'b0;
            end else if (strobe_fall) begin
                nib_phase <= ~nib_phase;
                if (!nib_phase) begin
                    hi_nib <= data_in[DATA_W-1 -: NIB_W];
                end
            end
        end
    end

    // Read return
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_byte     <= '0;
            data_out    <= '0;
            data_oe_out <= 1'b0;
        end else begin
            data_oe_out <= strobe_in & read_in;
            if (first_rise && read_in) begin
                rd_byte  <= sel_byte;
                data_out <= ctl.bus_width ? sel_byte
                          : {sel_byte[DATA_W-1 -: NIB_W], NIB_ZERO};
            end else if (strobe_rise && read_in) begin
                data_out <= {rd_byte[NIB_W-1:0], NIB_ZERO};
            end
        end
    end

    // Instruction and payload latch
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            instr_reg   <= '0;
            payload_reg <= '0;
            op_q        <= OP_NONE;
        end else begin
            op_q <= next_op;
            if (accept && !read_in && !reg_sel_in) begin
                instr_reg <= wr_byte;
            end
            if (accept && !read_in && reg_sel_in) begin
                payload_reg <= wr_byte;
            end
        end
    end

    // Execution state
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl          <= CTL_RESET;
            addr_counter <= ADDR_ZERO;
            disp_offset  <= ADDR_ZERO;
            sel_text     <= 1'b1;
        end else begin
            ctl          <= next_ctl;
            addr_counter <= next_addr;
            disp_offset  <= next_offset;
            sel_text     <= next_sel;
        end
    end

    // Space fill after clear
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fill_active <= 1'b0;
            fill_idx    <= ADDR_ZERO;
        end else if (exec_instr && cmd == CMD_CLR) begin
            fill_active <= 1'b1;
            fill_idx    <= ADDR_ZERO;
        end else if (fill_active) begin
            fill_idx    <= fill_idx + 1'b1;
            fill_active <= (fill_idx != TEXT_LAST);
        end
    end

    // Display outputs
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            screen_on_out      <= 1'b0;
            cursor_show_out    <= 1'b0;
            blink_show_out     <= 1'b0;
            two_line_out       <= 1'b0;
            tall_font_out      <= 1'b0;
            bus_width_out      <= 1'b1;
            display_offset_out <= ADDR_ZERO;
            cursor_addr_out    <= ADDR_ZERO;
        end else begin
            screen_on_out      <= ctl.screen_on;
            cursor_show_out    <= ctl.screen_on & ctl.cursor_on;
            blink_show_out     <= ctl.screen_on & ctl.blink_on;
            two_line_out       <= ctl.two_line;
            tall_font_out      <= ctl.tall_font;
            bus_width_out      <= ctl.bus_width;
            display_offset_out <= disp_offset;
            cursor_addr_out    <= addr_counter;
        end
    end

    cld_exec_timer u_timer (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .load_in    (tmr_load),
        .count_in   (exec_cyc),
        .busy_out   (tmr_busy)
    );

    cld_ram #(.AW(TEXT_AW)) u_text_ram (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (text_we),
        .wr_addr_in  (text_wa),
        .wr_data_in  (text_wd),
        .rd_addr_in  (addr_counter),
        .rd_data_out (text_rd)
    );

    cld_ram #(.AW(GLYPH_AW)) u_glyph_ram (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (glyph_we),
        .wr_addr_in  (addr_counter[GLYPH_AW-1:0]),
        .wr_data_in  (payload_reg),
        .rd_addr_in  (addr_counter[GLYPH_AW-1:0]),
        .rd_data_out (glyph_rd)
    );

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_first_nib;
        strobe_fall && !ctl.bus_width && !nib_phase;
    endsequence

    sequence s_second_nib;
        strobe_fall && !ctl.bus_width && nib_phase;
    endsequence

    sequence s_status_rd;
        first_rise && read_in && !reg_sel_in && ctl.bus_width;
    endsequence

    a_latch_instr: assert property (
        accept && !read_in && !reg_sel_in
        |=> instr_reg == $past(wr_byte) && op_q == OP_INSTR)
        else $error("instruction not latched");

    a_step_access: assert property (
        (exec_write || exec_read) && !sel_text
        |=> addr_counter[GLYPH_AW-1:0] == ($past(ctl.step_inc)
            ? $past(addr_counter[GLYPH_AW-1:0]) + 1'b1
            : $past(addr_counter[GLYPH_AW-1:0]) - 1'b1))
        else $error("address counter did not step");

    a_status_busy: assert property (
        s_status_rd ##0 busy_flag
        |=> data_out[BIT_BUSY] && data_out[TEXT_AW-1:0] == $past(addr_counter))
        else $error("status read lost busy or address");

    a_clear_home: assert property (
        exec_instr && cmd == CMD_CLR
        |=> addr_counter == ADDR_ZERO && ctl.step_inc ##0 fill_active[*8])
        else $error("clear did not reset address or fill");

    a_long_busy: assert property (
        exec_long |=> busy_flag[*8] ##0 disp_offset == ADDR_ZERO)
        else $error("long command not busy");

    a_scroll_write: assert property (
        exec_write && sel_text && ctl.auto_scroll
        |=> disp_offset == ($past(ctl.step_inc) ? $past(disp_offset) + 1'b1
                                                : $past(disp_offset) - 1'b1))
        else $error("auto scroll shifted the wrong way");

    a_no_scroll: assert property (
        exec_read || (exec_write && !(sel_text && ctl.auto_scroll))
        |=> $stable(disp_offset))
        else $error("display shifted without cause");

    a_addr_load: assert property (
        exec_instr && cmd == CMD_CGA
        |=> !sel_text
        && addr_counter == {1'b0, $past(instr_reg[GLYPH_AW-1:0])})
        else $error("glyph address not loaded");

    a_nib_pair: assert property (
        s_second_nib |-> byte_done ##1 !nib_phase)
        else $error("nibble pairing broken");

    a_first_nib: assert property (
        s_first_nib |=> hi_nib == $past(data_in[DATA_W-1 -: NIB_W])
        && nib_phase && !byte_done)
        else $error("upper nibble not captured first");

    a_refuse_busy: assert property (
        byte_done && busy_flag && !read_in |=> op_q == OP_NONE)
        else $error("transfer taken while busy");

endmodule : cld_decoder
`default_nettype wire

// ### cld_pkg.sv
`default_nettype none
package cld_pkg;

    // Clock and execution times
    localparam int CLK_PERIOD_NS  = 10;
    localparam int EXEC_CLR_NS    = 1530000;
    localparam int EXEC_SHORT_NS  = 39000;
    localparam int EXEC_DATA_NS   = 43000;
    localparam int EXEC_CLR_CYC   =
        (EXEC_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXEC_SHORT_CYC =
        (EXEC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXEC_DATA_CYC  =
        (EXEC_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W          = 18;

    // Widths
    localparam int DATA_W   = 8;
    localparam int NIB_W    = 4;
    localparam int TEXT_AW  = 7;
    localparam int GLYPH_AW = 6;

    // Text address map
    localparam logic [TEXT_AW-1:0] ADDR_ZERO    = 7'h00;
    localparam logic [TEXT_AW-1:0] LINE1_END    = 7'h27;
    localparam logic [TEXT_AW-1:0] LINE2_START  = 7'h40;
    localparam logic [TEXT_AW-1:0] LINE2_END    = 7'h67;
    localparam logic [TEXT_AW-1:0] ONE_LINE_END = 7'h4F;
    localparam logic [TEXT_AW-1:0] TEXT_LAST    = 7'h7F;
    localparam logic [DATA_W-1:0]  SPACE_CODE   = 8'h20;
    localparam logic [NIB_W-1:0]   NIB_ZERO     = 4'h0;

    // Command leading-one positions
    localparam int CMD_DDADDR = 7;
    localparam int CMD_CGADDR = 6;
    localparam int CMD_FUNC   = 5;
    localparam int CMD_SHIFT  = 4;
    localparam int CMD_ONOFF  = 3;
    localparam int CMD_ENTRY  = 2;
    localparam int CMD_HOME   = 1;
    localparam int CMD_CLEAR  = 0;

    // Argument bit positions
    localparam int BIT_STEP_INC = 1;
    localparam int BIT_SCROLL   = 0;
    localparam int BIT_SCREEN   = 2;
    localparam int BIT_CURSOR   = 1;
    localparam int BIT_BLINK    = 0;
    localparam int BIT_TARGET   = 3;
    localparam int BIT_RIGHT    = 2;
    localparam int BIT_WIDTH    = 4;
    localparam int BIT_LINES    = 3;
    localparam int BIT_FONT     = 2;
    localparam int BIT_BUSY     = 7;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_INSTR,
        OP_WRITE,
        OP_READ
    } cld_op_e;

    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_CLR,
        CMD_HOM,
        CMD_ENT,
        CMD_ONF,
        CMD_SHF,
        CMD_FUN,
        CMD_CGA,
        CMD_DDA
    } cld_cmd_e;

    typedef struct packed {
        logic screen_on;
        logic cursor_on;
        logic blink_on;
        logic step_inc;
        logic auto_scroll;
        logic bus_width;
        logic two_line;
        logic tall_font;
    } cld_ctl_s;

    localparam cld_ctl_s CTL_RESET = '{
        screen_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0,
        step_inc: 1'b1, auto_scroll: 1'b0, bus_width: 1'b1,
        two_line: 1'b0, tall_font: 1'b0};

endpackage : cld_pkg
`default_nettype wire

// ### cld_exec_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cld_exec_timer
    import cld_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_in,
    // Load
    input  wire logic             load_in,
    input  wire logic [TMR_W-1:0] count_in,
    // Status
    output logic                  busy_out
);

    logic [TMR_W-1:0] remain;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            remain <= '0;
        end else if (load_in) begin
            remain <= count_in;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign busy_out = (remain != '0);

endmodule : cld_exec_timer
`default_nettype wire

// ### cld_ram.sv
`timescale 1ns/1ps
`default_nettype none
module cld_ram
    import cld_pkg::*;
#(
    parameter int AW = TEXT_AW
)
(
    // Clock
    input  wire logic              sys_clk_in,
    // Write port
    input  wire logic              wr_en_in,
    input  wire logic [AW-1:0]     wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    // Read port
    input  wire logic [AW-1:0]     rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out
);

    logic [DATA_W-1:0] mem [2**AW];

    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = mem[rd_addr_in];

endmodule : cld_ram
`default_nettype wire

// ### cld_host.sv
`timescale 1ns/1ps
`default_nettype none
module cld_host
    import cld_pkg::*;
(
    // Bus from the controller
    input  wire logic              sys_clk_in,
    input  wire logic [DATA_W-1:0] data_in,
    // Bus to the controller
    output logic                   reg_sel_out = 1'b0,
    output logic                   read_out    = 1'b0,
    output logic                   strobe_out  = 1'b0,
    output logic      [DATA_W-1:0] data_out    = 8'h00
);
    // Strobe high two cycles, low two cycles
    task automatic xfer(input logic rs, input logic rd,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
        @(posedge sys_clk_in);
        reg_sel_out <= rs;
        read_out    <= rd;
        data_out    <= d;
        strobe_out  <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        q = data_in;
        strobe_out <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        data_out <= ~d; // Released lines do not keep the old byte
    endtask : xfer
endmodule : cld_host
`default_nettype wire

// ### tb_char_lcd_instruction_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_char_lcd_instruction_decoder;
    import cld_pkg::*;
    logic               clk = 1'b0, rst = 1'b1, oe_q = 1'b0, narrow = 1'b0;
    logic               rs, rd, stb, oe;
    logic [DATA_W-1:0]  din, dout, q, r;
    logic [TEXT_AW-1:0] ofs, cur;
    wire  [5:0]         ctl;
    logic [8:0]         notes[$];
    int                 n_fail = 0, samples_checked = 0, seed = 32'h3AE7D51C;
    // Half period of the nominal execution clock
    localparam int OSC_HZ       = 270000;
    localparam int HALF_OSC_CYC = 1000000000 / (2 * OSC_HZ * CLK_PERIOD_NS) + 1;
    always #5 clk = ~clk;
    cld_host host (.sys_clk_in(clk), .data_in(dout), .reg_sel_out(rs),
        .read_out(rd), .strobe_out(stb), .data_out(din));
    cld_decoder #(.CLR_CYC(200), .DATA_CYC(20)) dut (.sys_clk_in(clk),
        .reset_in(rst), .reg_sel_in(rs), .read_in(rd), .strobe_in(stb),
        .data_in(din), .data_out(dout), .data_oe_out(oe),
        .screen_on_out(ctl[5]), .cursor_show_out(ctl[4]),
        .blink_show_out(ctl[3]), .two_line_out(ctl[2]),
        .tall_font_out(ctl[1]), .bus_width_out(ctl[0]),
        .display_offset_out(ofs), .cursor_addr_out(cur));
    // Each read answer takes the oldest note
    always @(posedge clk) begin
        oe_q <= oe;
        if (oe && !oe_q && notes.size() > 0) begin
            if (notes[0][8]) `CHK("read data", notes[0][7:0], dout)
            void'(notes.pop_front());
        end
    end
    task automatic op(input logic rs_v, rd_v, care,
                      input logic [7:0] d, e);
        logic [7:0] lo;
        if (rd_v && !narrow) notes.push_back({care, e});
        if (rd_v && narrow) notes.push_back({care, e[7:4], 4'h0});
        if (rd_v && narrow) notes.push_back({care, e[3:0], 4'h0});
        host.xfer(rs_v, rd_v, d, q);
        if (narrow) host.xfer(rs_v, rd_v, {d[3:0], 4'h0}, lo);
    endtask : op
    task automatic idle;
        q = 8'h80;
        for (int i = 0; i < 2000 && q[BIT_BUSY] !== 1'b0; i++)
            op(0, 1, 0, 0, 0);
        if (q[BIT_BUSY] !== 1'b0) `CHK("busy wait", 1'b0, 1'b1)
        repeat (HALF_OSC_CYC) @(posedge clk);
    endtask : idle
    task automatic cmd(input logic [7:0] d);
        op(0, 0, 0, d, 0);
        idle;
    endtask : cmd
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        r = 8'($random(seed));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cmd(8'h3C);
        `CHK("func set", 3'b111, ctl[2:0])
        cmd(8'h0B);
        `CHK("screen off", 3'b000, ctl[5:3])
        cmd(8'h0D);
        `CHK("on off", 3'b101, ctl[5:3])
        $display("test controls done");
        cmd(8'hA7);
        op(1, 0, 0, r, 0);
        // Instruction sent while busy must be dropped
        op(0, 0, 0, 8'h80, 0);
        op(0, 1, 1, 0, 8'hC0);
        idle;
        cmd(8'hA7);
        op(1, 1, 1, 0, r);
        idle;
        op(0, 1, 1, 0, 8'h40);
        cmd(8'h05);
        cmd(8'h85);
        op(1, 0, 0, r, 0);
        idle;
        `CHK("offset", 7'h7F, ofs)
        op(0, 1, 1, 0, 8'h04);
        $display("test ram done");
        cmd(8'h02);
        `CHK("home", 14'h0000, {ofs, cur})
        cmd(8'h14);
        cmd(8'h18);
        `CHK("shift", 14'h0081, {ofs, cur})
        cmd(8'h45);
        op(1, 0, 0, ~r, 0);
        idle;
        cmd(8'h45);
        op(1, 1, 1, 0, ~r);
        idle;
        op(0, 1, 1, 0, 8'h04);
        `CHK("glyph scroll", 7'h01, ofs)
        op(0, 0, 0, 8'h28, 0);
        narrow = 1'b1;
        idle;
        `CHK("narrow", 1'b0, ctl[0])
        op(0, 1, 1, 0, 8'h04);
        op(0, 0, 0, 8'h38, 0);
        narrow = 1'b0;
        idle;
        `CHK("wide", 1'b1, ctl[0])
        $display("test shift glyph narrow done");
        cmd(8'h01);
        op(1, 1, 1, 0, SPACE_CODE);
        idle;
        op(0, 1, 1, 0, 8'h01);
        $display("test clear done");
        tally_and_finish;
    end
    initial begin
        #900000;
        n_fail++;
        tally_and_finish;
    end
endmodule : tb_char_lcd_instruction_decoder
`default_nettype wire
